// ===== rtl/pcs_pkg.sv
/*
  pcs_pkg: constants for the program counter and return stack unit.
  assumes: included before the unit; all uses are scoped, nothing imported.
*/
package pcs_pkg;

  // ****************************************
  // register bus map (word offsets as byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_LOW_BYTE    = 8'h00;
  localparam logic [7:0] OFS_UPPER_LATCH = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_INDIRECT    = 8'h0C;
  localparam logic [7:0] OFS_PC_VIEW     = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BANK_HI_POS = 6;
  localparam int BANK_LO_POS = 5;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int PC_W        = 13;
  localparam int TARGET_W    = 11;
  localparam int BANK_ADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SFR_TOP     = 32;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  FSR_RST    = 8'h00;
  localparam logic [2:0]  SP_RST     = 3'h0;

  // mirrored special registers: reachable in every bank at these offsets
  localparam logic [6:0] MIRROR_0 = 7'h02;
  localparam logic [6:0] MIRROR_1 = 7'h03;
  localparam logic [6:0] MIRROR_2 = 7'h04;
  localparam logic [6:0] MIRROR_3 = 7'h0A;

  // sequencing operations from instruction decode
  typedef enum logic [2:0] {
    PCS_OP_STEP,
    PCS_OP_CALL,
    PCS_OP_JUMP,
    PCS_OP_RETURN,
    PCS_OP_RET_LIT,
    PCS_OP_RET_INT,
    PCS_OP_VECTOR,
    PCS_OP_HOLD
  } pcs_op_type;

endpackage

// ===== rtl/pcs_unit.sv
/*
  pcs_unit: program counter, counter latch, circular return stack and data
  bank address formation of an 8-bit core.
  assumes: decode issues one op per clock; register bus is Avalon-MM slave.
*/
// The Avalon-MM slave port and the address map were decided locally.
// Behaviour
// - status bits 6:5 select bank for direct access; indirect uses status bit 7 and fsr bit 7
// - bank spans 128 bytes, bank on top
// - special registers low, general RAM above
// - some special registers mirrored across banks
// - direct or indirect register file addressing
// - program counter is 13 bits
// - counter low byte read and written
// - upper counter bits only via latch
// - any reset clears upper counter bits
// - low byte write copies latch 4:0 to top
// - call/jump take top bits from latch
// - call/jump carry 11-bit target
// - eight 13-bit stack entries, separate space
// - stack pointer invisible to software
// - push on call or interrupt vector
// - pop on return, literal, interrupt return
// - push and pop leave latch alone
// - stack wraps circularly, ninth overwrites first
// - no overflow or underflow indication
`timescale 1ns/1ps
module pcs_unit #(
  parameter int          STACK_DEPTH = pcs_pkg::STACK_DEPTH,
  parameter logic [12:0] INT_VECTOR  = 13'h0004
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // instruction decode
  input  wire logic [2:0]  op_i,
  input  wire logic [10:0] target_i,
  input  wire logic        file_write_i,
  input  wire logic [6:0]  file_addr_i,
  input  wire logic        file_indirect_i,
  input  wire logic [7:0]  file_wdata_i,
  // sequencing outputs
  output logic [12:0]      pc_o,
  output logic [8:0]       data_addr_o,
  output logic             data_sfr_o,
  output logic [1:0]       bank_o,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ****************************************
  // state
  // ****************************************
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [12:0]    pc_r;
  logic [7:0]     latch_r;
  logic [7:0]     status_r;
  logic [7:0]     fsr_r;
  logic [SP_W-1:0] sp_r;
  logic [12:0]    stack_r [STACK_DEPTH];
  logic           ack_r;
  logic [31:0]    rdata_r;
  logic [12:0]    pc_nxt;
  logic [12:0]    pc_inc;
  logic [6:0]     eff_off;
  logic [1:0]     eff_bank;
  logic           bus_acc;
  logic           low_wr;
  logic           core_low;
  pcs_pkg::pcs_op_type op;

  assign op = pcs_pkg::pcs_op_type'(op_i);

  // single wait state: request taken on the edge where ack_r is high
  assign bus_acc         = (avs_read | avs_write) & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // match a direct/indirect file address against an offset in any bank
  function automatic logic file_hit(input logic [6:0] off, input logic [6:0] want);
    return off == want;
  endfunction

  // ****************************************
  // data memory addressing
  // ****************************************
  // direct or indirect address
  assign eff_off  = file_indirect_i ? fsr_r[6:0] : file_addr_i;
  assign eff_bank = file_indirect_i ? {status_r[7], fsr_r[7]}
                  : {status_r[pcs_pkg::BANK_HI_POS], status_r[pcs_pkg::BANK_LO_POS]};
  assign bank_o   = {status_r[pcs_pkg::BANK_HI_POS], status_r[pcs_pkg::BANK_LO_POS]};

  always_comb begin
    // bank on top of 7-bit offset
    data_addr_o = {eff_bank, eff_off};
    // mirrored registers fold to bank 0
    if (file_hit(eff_off, pcs_pkg::MIRROR_0) || file_hit(eff_off, pcs_pkg::MIRROR_1) ||
        file_hit(eff_off, pcs_pkg::MIRROR_2) || file_hit(eff_off, pcs_pkg::MIRROR_3)) begin
      data_addr_o = {2'b00, eff_off};
    end
  end

  assign data_sfr_o = eff_off < 7'(pcs_pkg::SFR_TOP);

  // low byte writes from the core or the bus
  // core write to the low byte wins the data over a bus write in the same cycle
  assign core_low = file_write_i && file_hit(eff_off, pcs_pkg::MIRROR_0);
  assign low_wr   = core_low
                  | (bus_acc && avs_write && avs_address == pcs_pkg::OFS_LOW_BYTE);

  // ****************************************
  // program counter
  // ****************************************
  assign pc_inc = pc_r + 13'h0001;

  always_comb begin
    pc_nxt = pc_inc;
    unique case (op)
      pcs_pkg::PCS_OP_STEP:   pc_nxt = pc_inc;
      // latch 4:3 on top of target
      pcs_pkg::PCS_OP_CALL,
      pcs_pkg::PCS_OP_JUMP:   pc_nxt = {latch_r[4:3], target_i};
      pcs_pkg::PCS_OP_RETURN,
      pcs_pkg::PCS_OP_RET_LIT,
      pcs_pkg::PCS_OP_RET_INT: pc_nxt = stack_r[sp_r - SP_W'(1)];
      pcs_pkg::PCS_OP_VECTOR: pc_nxt = INT_VECTOR;
      pcs_pkg::PCS_OP_HOLD:   pc_nxt = pc_r;
    endcase
    // low byte write copies latch 4:0
    if (low_wr) begin
      pc_nxt = {latch_r[4:0], (core_low ? file_wdata_i : avs_writedata[7:0])};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r <= pcs_pkg::PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign pc_o = pc_r;

  // ****************************************
  // return stack
  // ****************************************
  // eight entries outside address spaces
  always_ff @(posedge mclk_i) begin
    if (op == pcs_pkg::PCS_OP_CALL) begin
      stack_r[sp_r] <= pc_inc;
    end else if (op == pcs_pkg::PCS_OP_VECTOR) begin
      stack_r[sp_r] <= pc_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_r <= SP_W'(pcs_pkg::SP_RST);
    end else if (op == pcs_pkg::PCS_OP_CALL || op == pcs_pkg::PCS_OP_VECTOR) begin
      sp_r <= sp_r + SP_W'(1);
    end else if (op == pcs_pkg::PCS_OP_RETURN || op == pcs_pkg::PCS_OP_RET_LIT ||
                 op == pcs_pkg::PCS_OP_RET_INT) begin
      sp_r <= sp_r - SP_W'(1);
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // upper bits only via latch
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r <= pcs_pkg::LATCH_RST;
    end else if (file_write_i && file_hit(eff_off, pcs_pkg::MIRROR_3)) begin
      latch_r <= {3'h0, file_wdata_i[4:0]};
    end else if (bus_acc && avs_write && avs_address == pcs_pkg::OFS_UPPER_LATCH) begin
      latch_r <= {3'h0, avs_writedata[4:0]};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= pcs_pkg::STATUS_RST;
    end else if (file_write_i && file_hit(eff_off, pcs_pkg::MIRROR_1)) begin
      status_r <= file_wdata_i;
    end else if (bus_acc && avs_write && avs_address == pcs_pkg::OFS_STATUS) begin
      status_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsr_r <= pcs_pkg::FSR_RST;
    end else if (file_write_i && file_hit(eff_off, pcs_pkg::MIRROR_2)) begin
      fsr_r <= file_wdata_i;
    end else if (bus_acc && avs_write && avs_address == pcs_pkg::OFS_INDIRECT) begin
      fsr_r <= avs_writedata[7:0];
    end
  end

  // read data, captured on the wait cycle and held while ack is up
  // low byte readable
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      unique case (avs_address)
        pcs_pkg::OFS_LOW_BYTE:    rdata_r <= {24'h00_0000, pc_r[7:0]};
        pcs_pkg::OFS_UPPER_LATCH: rdata_r <= {24'h00_0000, latch_r};
        pcs_pkg::OFS_STATUS:      rdata_r <= {24'h00_0000, status_r};
        pcs_pkg::OFS_INDIRECT:    rdata_r <= {24'h00_0000, fsr_r};
        default:                  rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_r;

endmodule // pcs_unit

// ===== verification/pcs_decode_model.sv
/* pcs_decode_model: instruction decode stand-in for pcs_unit.
   assumes: issue is called just after a rising edge of mclk_i. */
`timescale 1ns/1ps
module pcs_decode_model (
  // clock
  input  wire logic   mclk_i,
  // decode lines
  output logic [2:0]  op_o,
  output logic [10:0] target_o,
  output logic        file_write_o,
  output logic [6:0]  file_addr_o,
  output logic        file_indirect_o,
  output logic [7:0]  file_wdata_o
);
  initial {op_o, target_o, file_write_o, file_addr_o, file_indirect_o, file_wdata_o} = {3'h7, 28'h0};
  task issue(input logic [2:0] op, input logic [10:0] t, input logic w, i,
             input logic [6:0] a, input logic [7:0] d);
    op_o <= op;
    target_o <= t;
    file_write_o <= w;
    file_indirect_o <= i;
    file_addr_o <= a;
    file_wdata_o <= d;
    @(posedge mclk_i);
    op_o <= 3'h7;
    file_write_o <= 1'b0;
  endtask
endmodule // pcs_decode_model

// ===== verification/pcs_unit_props.sv
/* pcs_unit_props: port assertions for pcs_unit.
   assumes: bound to pcs_unit; one clock, async active-low reset. */
`timescale 1ns/1ps
module pcs_unit_props #(
  parameter int          STACK_DEPTH = 8,
  parameter logic [12:0] INT_VECTOR  = 13'h0004
) (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // core side
  input wire logic [2:0]  op_i,
  input wire logic [10:0] target_i,
  input wire logic        file_write_i,
  input wire logic [6:0]  file_addr_i,
  input wire logic        file_indirect_i,
  input wire logic [12:0] pc_o,
  input wire logic [8:0]  data_addr_o,
  input wire logic        data_sfr_o,
  input wire logic [1:0]  bank_o,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  // no low-byte write can override the op
  wire logic quiet   = !file_write_i && !avs_write;
  wire logic plain_a = !file_indirect_i && !(file_addr_i inside {7'h02, 7'h03, 7'h04, 7'h0A});
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_call_jump_low: assert property (quiet && (op_i == 3'h1 || op_i == 3'h2) |=>
    pc_o[10:0] == $past(target_i)) else $error("call or jump target not loaded");
  a_vector_load: assert property (quiet && op_i == 3'h6 |=> pc_o == INT_VECTOR)
    else $error("vector address not loaded");
  a_step_incr: assert property (quiet && op_i == 3'h0 |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("step did not advance counter");
  a_hold_still: assert property (quiet && op_i == 3'h7 |=> $stable(pc_o))
    else $error("counter moved on hold");
  a_bank_addr: assert property (plain_a |-> data_addr_o == {bank_o, file_addr_i})
    else $error("direct data address wrong");
  a_sfr_flag: assert property (data_sfr_o == (data_addr_o[6:0] < 7'h20))
    else $error("special register flag wrong");
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("bus answer timing wrong");
  a_reset_clear: assert property ($rose(rst_n_i) |-> pc_o == 13'h0000 && bank_o == 2'h0)
    else $error("counter not cleared by reset");
  a_ret_after_call: assert property (quiet && op_i == 3'h1 ##1 quiet && op_i == 3'h7 ##1
    quiet && op_i == 3'h3 |=> pc_o == $past(pc_o, 3) + 13'h0001) else $error("return address wrong");
  c_call: cover property (op_i == 3'h1);
  c_vector: cover property (op_i == 3'h6);
  c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule // pcs_unit_props

bind pcs_unit pcs_unit_props #(.STACK_DEPTH(STACK_DEPTH), .INT_VECTOR(INT_VECTOR)) u_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_i(op_i), .target_i(target_i),
  .file_write_i(file_write_i), .file_addr_i(file_addr_i), .file_indirect_i(file_indirect_i),
  .pc_o(pc_o), .data_addr_o(data_addr_o), .data_sfr_o(data_sfr_o), .bank_o(bank_o),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// ===== verification/pcs_unit_tb.sv
/* pcs_unit_tb: self-checking bench for pcs_unit.
   assumes: decode model drives the core side, the bench drives the bus. */
`timescale 1ns/1ps
module pcs_unit_tb;
  logic        mclk_i, rst_n_i, avs_read, avs_write, avs_waitrequest;
  logic        file_write_i, file_indirect_i, data_sfr_o;
  logic [2:0]  op_i;
  logic [10:0] target_i;
  logic [6:0]  file_addr_i;
  logic [7:0]  file_wdata_i, avs_address;
  logic [12:0] pc_o;
  logic [8:0]  data_addr_o;
  logic [1:0]  bank_o;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          mismatches, checks;
  // op, target, expected counter
  logic [26:0] rows [9] = '{{3'h2, 11'h123, 13'h1923}, {3'h0, 11'h000, 13'h1924},
    {3'h1, 11'h055, 13'h1855}, {3'h1, 11'h100, 13'h1900}, {3'h3, 11'h000, 13'h1856},
    {3'h4, 11'h000, 13'h1925}, {3'h6, 11'h000, 13'h0004}, {3'h5, 11'h000, 13'h1925},
    {3'h7, 11'h000, 13'h1925}};
  pcs_unit u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_i(op_i), .target_i(target_i),
    .file_write_i(file_write_i), .file_addr_i(file_addr_i), .file_indirect_i(file_indirect_i),
    .file_wdata_i(file_wdata_i), .pc_o(pc_o), .data_addr_o(data_addr_o),
    .data_sfr_o(data_sfr_o), .bank_o(bank_o), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  pcs_decode_model u_dec (.mclk_i(mclk_i), .op_o(op_i), .target_o(target_i),
    .file_write_o(file_write_i), .file_addr_o(file_addr_i),
    .file_indirect_o(file_indirect_i), .file_wdata_o(file_wdata_i));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, d);
    @(posedge mclk_i);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task step(input logic [2:0] op, input logic [10:0] t, input logic w, i,
            input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    u_dec.issue(op, t, w, i, a, d);
    @(negedge mclk_i);
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
  initial begin
    {mismatches, checks} = '0;
    {rst_n_i, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1'b1, 8'h04, 8'h18);
    for (int k = 0; k < 9; k++) begin
      step(rows[k][26:24], rows[k][23:13], 1'b0, 1'b0, 7'h40, 8'h00);
      chk("pc", 32'(pc_o), 32'(rows[k][12:0]));
    end
    bus(1'b0, 8'h04, 8'h00);
    chk("latch", q, 32'h18);
    bus(1'b0, 8'h00, 8'h00);
    chk("low", q, 32'h25);
    bus(1'b0, 8'h10, 8'h00);
    chk("upper", q, 32'h0);
    bus(1'b1, 8'h00, 8'h40);
    step(3'h7, 11'h000, 1'b0, 1'b0, 7'h40, 8'h00);
    chk("busload", 32'(pc_o), 32'h1840);
    step(3'h1, 11'h000, 1'b1, 1'b0, 7'h02, 8'h77);
    chk("coreload", 32'(pc_o), 32'h1877);
    $display("test table done");
    for (int k = 1; k < 10; k++) step(3'h1, 11'(k), 1'b0, 1'b0, 7'h40, 8'h00);
    for (int k = 1; k < 10; k++) begin
      step(3'h3, 11'h000, 1'b0, 1'b0, 7'h40, 8'h00);
      chk("wrap", 32'(pc_o), (k == 9) ? 32'h1809 : 32'h180A - 32'(k));
    end
    $display("test wrap done");
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, 8'h08, 8'(b * 32));
      step(3'h7, 11'h000, 1'b0, 1'b0, 7'h40, 8'h00);
      chk("bank", 32'(bank_o), 32'(b));
      chk("daddr", 32'(data_addr_o), 32'(b * 128 + 64));
      chk("sfr", 32'(data_sfr_o), 32'h0);
    end
    step(3'h7, 11'h000, 1'b0, 1'b0, 7'h03, 8'h00);
    chk("mirror", 32'(data_addr_o), 32'h003);
    chk("sfr", 32'(data_sfr_o), 32'h1);
    bus(1'b1, 8'h0C, 8'h85);
    step(3'h7, 11'h000, 1'b0, 1'b1, 7'h40, 8'h00);
    chk("indirect", 32'(data_addr_o), 32'h085);
    $display("test banks done");
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("rstpc", 32'(pc_o), 32'h0);
    rst_n_i <= 1'b1;
    step(3'h1, 11'h010, 1'b0, 1'b0, 7'h40, 8'h00);
    step(3'h3, 11'h000, 1'b0, 1'b0, 7'h40, 8'h00);
    chk("rstsp", 32'(pc_o), 32'h0001);
    // pop after one call and return since reset reads the last entry, left from the wrap test
    step(3'h3, 11'h000, 1'b0, 1'b0, 7'h40, 8'h00);
    chk("rstpop", 32'(pc_o), 32'h1807);
    $display("test reset done");
    final_report();
  end
endmodule // pcs_unit_tb
